// file: rtl/mem_init_seq.sv
// Purpose: power-on memory bring-up sequencer with error reporting
// Assumes: channel-side engines answer each request with a done pulse
// Notes:   codes leave one per cycle on O_CODE with O_CODE_VALID
`timescale 1ns/1ps
`include "mem_init_seq_defines.svh"
module mem_init_seq
  import mem_init_seq_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int SLOTS    = 3
) (
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_RST,
  input  wire logic                        i_start,
  input  wire logic                        i_mem_locked,
  input  wire slot_info_t [CHANNELS*SLOTS-1:0] i_slot_info,
  input  wire logic                        i_step_done,
  input  wire logic [CHANNELS-1:0]         i_train_ok,
  input  wire logic                        i_thermal_cfg_err,
  input  wire logic [CHANNELS*SLOTS-1:0]   i_selftest_fail,
  input  wire logic [1:0]                  i_ras_select,
  input  wire logic [3:0]                  i_spare_ranks,
  input  wire logic [3:0]                  i_total_ranks,
  input  wire logic                        i_rd_correctable,
  input  wire logic                        i_patrol_uncorrected,
  output logic                             o_step_req,
  output code_t                            O_CODE,
  output logic                             O_CODE_VALID,
  output logic [CHANNELS*SLOTS-1:0]        O_DIMM_ENABLE,
  output logic                             O_ECC_ENABLE,
  output logic                             O_ZERO_FILL,
  output logic [1:0]                       O_RAS_MODE,
  output logic                             O_WRITE_BACK,
  output logic                             O_POISON,
  output logic                             O_HALTED
);
  localparam int N = CHANNELS * SLOTS;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // disable a slot and every slot behind it on the channel
  function automatic logic [N-1:0] cascade(input logic [N-1:0] en, input int idx);
    logic [N-1:0] r;
    r = en;
    for (int s = 0; s < SLOTS; s++) begin
      if ((idx % SLOTS) <= s) r[(idx / SLOTS) * SLOTS + s] = 1'b0;
    end
    return r;
  endfunction : cascade

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  state_t           st_q, st_d, ret_q, ret_d;
  logic [N-1:0]     en_q, en_d, pend_q, pend_d;
  logic [15:0]      tag_q, tag_d;
  logic [N-1:0]     err_q, err_d;
  code_t            code_q, code_d;
  logic             cv_q, cv_d, ecc_q, ecc_d, zf_q, zf_d, req_q, req_d;
  logic [1:0]       ras_q, ras_d;
  logic             halt_q, halt_d, wb_q, wb_d, poi_q, poi_d;
  logic [7:0]       hcode_q, hcode_d;
  logic             ras_ok;
  logic             any_lr, any_rd, any_dm, any_rm, fatal_pop, tr_any;
  logic [N-1:0]     fill_bad, disc_en;

  // --------------------------------------------------------------
  // combinational population checks
  // --------------------------------------------------------------
  always_comb begin
    any_lr = 1'b0;
    any_rd = 1'b0;
    any_dm = 1'b0;
    any_rm = 1'b0;
    fatal_pop = 1'b0;
    fill_bad = '0;
    for (int i = 0; i < N; i++) begin
      if (i_slot_info[i].present && !i_slot_info[i].read_err) begin
        any_lr |= i_slot_info[i].load_reduced;
        any_rd |= !i_slot_info[i].load_reduced;
        any_dm |= i_slot_info[i].load_reduced && !i_slot_info[i].rank_mult;
        any_rm |= i_slot_info[i].load_reduced && i_slot_info[i].rank_mult;
        if (!i_slot_info[i].supported) fatal_pop = 1'b1;
        // rank multiplication 2/4 lets a quad-rank sit in slot 2
        if ((i % SLOTS) == 2 && SLOTS == 3 && i_slot_info[i].quad_rank &&
            !(i_slot_info[i].load_reduced && i_slot_info[i].rank_mult &&
              (i_slot_info[i].rm_factor == `RM_TWO ||
               i_slot_info[i].rm_factor == `RM_FOUR))) fatal_pop = 1'b1;
        if ((i % SLOTS) != 0 && !i_slot_info[i-1].present)
          fill_bad[(i / SLOTS) * SLOTS] = 1'b1;
      end
    end
    if ((any_lr && any_rd) || (any_dm && any_rm)) fatal_pop = 1'b1;
    // slots that survive discovery: present and not at or behind a read error
    disc_en = '0;
    for (int i = 0; i < N; i++) disc_en[i] = i_slot_info[i].present;
    for (int i = 0; i < N; i++) begin
      if (i_slot_info[i].present && i_slot_info[i].read_err) disc_en = cascade(disc_en, i);
    end
    // a trained but empty channel does not count as a working one
    tr_any = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (en_q[i] && i_train_ok[i / SLOTS]) tr_any = 1'b1;
    end
    // sparing limited in spare and total ranks; any mode needs an enabled slot
    ras_ok = (i_ras_select != 2'h2 || (i_spare_ranks <= `MAX_SPARE_RANKS &&
              i_total_ranks <= `MAX_RANKS)) && (|en_q);
  end

  // --------------------------------------------------------------
  // sequencer next state
  // --------------------------------------------------------------
  // a step is requested only on entry to its waiting state, so a fast done
  // pulse can never arrive while codes are still streaming out
  always_comb begin
    st_d    = st_q;
    ret_d   = ret_q;
    en_d    = en_q;
    pend_d  = pend_q;
    tag_d   = tag_q;
    err_d   = err_q;
    code_d  = code_q;
    cv_d    = 1'b0;
    ecc_d   = ecc_q;
    zf_d    = zf_q;
    req_d   = 1'b0;
    ras_d   = ras_q;
    halt_d  = halt_q;
    hcode_d = hcode_q;
    wb_d    = 1'b0;
    poi_d   = 1'b0;
    case (st_q)
      ST_IDLE: if (i_start) st_d = ST_DISCVR;
      ST_DISCVR: begin
        if (i_mem_locked) begin
          hcode_d = `HALT_LOCKED;
          st_d    = ST_HALT;
        end else begin
          // channels with a hole stay off from the start; popcheck reports them
          for (int i = 0; i < N; i++) begin
            err_d[i]  = i_slot_info[i].present && i_slot_info[i].read_err;
            pend_d[i] = i_slot_info[i].present && !disc_en[i];
            en_d[i]   = disc_en[i] && !fill_bad[(i / SLOTS) * SLOTS];
          end
          tag_d = `ERR_PRESENCE;
          ret_d = ST_POPCHK;
          st_d  = ST_EMIT;
        end
      end
      ST_POPCHK: begin
        if (fatal_pop) begin
          code_d  = '{KIND_ERROR, `ERR_POPULATION};
          cv_d    = 1'b1;
          hcode_d = `HALT_POPULATION;
          st_d    = ST_HALT;
        end else begin
          err_d = '0;
          for (int i = 0; i < N; i++) begin
            pend_d[i] = fill_bad[(i / SLOTS) * SLOTS] && disc_en[i];
          end
          if (|fill_bad) begin
            code_d = '{KIND_ERROR, `ERR_POPULATION};
            cv_d   = 1'b1;
          end
          tag_d = 16'h0;
          ret_d = ST_TRAIN;
          st_d  = ST_EMIT;
        end
      end
      ST_TRAIN: if (i_step_done) begin
        for (int i = 0; i < N; i++) begin
          if (!i_train_ok[i / SLOTS]) en_d[i] = 1'b0;
        end
        pend_d = en_q & ~en_d;
        err_d  = '0;
        tag_d  = 16'h0;
        if (|pend_d) begin
          code_d = '{KIND_PROGRESS, {8'h00, `HALT_TRAINING}};
          cv_d   = 1'b1;
        end
        // with no trained channel the 854x codes still go out before the halt
        if (!tr_any) begin
          hcode_d = `HALT_TRAINING;
          ret_d   = ST_HALT;
        end else begin
          ret_d = ST_THERMAL;
        end
        st_d = ST_EMIT;
      end
      ST_THERMAL: if (i_step_done) begin
        if (i_thermal_cfg_err) begin
          hcode_d = `HALT_THERMAL;
          st_d    = ST_HALT;
        end else begin
          st_d  = ST_SELFTST;
          req_d = 1'b1;
        end
      end
      ST_SELFTST: if (i_step_done) begin
        err_d = i_selftest_fail & en_q;
        for (int i = 0; i < N; i++) begin
          if (err_d[i]) en_d = cascade(en_d, i);
        end
        pend_d = en_q & ~en_d;
        tag_d  = `ERR_SELF_TEST;
        if (|err_d) begin
          code_d = '{KIND_PROGRESS, {8'h00, `SHOW_SELF_TEST}};
          cv_d   = 1'b1;
        end
        ret_d = ST_CLEAR;
        st_d  = ST_EMIT;
        zf_d  = 1'b1;
      end
      ST_CLEAR: if (i_step_done) begin
        zf_d  = 1'b0;
        ecc_d = 1'b1;
        st_d  = ST_RAS;
      end
      ST_RAS: begin
        if (ras_ok) begin
          ras_d = i_ras_select;
          st_d  = ST_RUN;
        end else begin
          // the event record follows on the next cycle via the pending tag
          ras_d  = 2'h0;
          code_d = '{KIND_ERROR, `ERR_RAS_FALLBACK};
          cv_d   = 1'b1;
          pend_d = '0;
          err_d  = '0;
          tag_d  = {8'h00, `SENSOR_RAS_TYPE};
          ret_d  = ST_RUN;
          st_d   = ST_EMIT;
        end
      end
      ST_RUN: begin
        wb_d = i_rd_correctable;
        poi_d = i_patrol_uncorrected;
      end
      ST_EMIT: begin
        if (tag_q == {8'h00, `SENSOR_RAS_TYPE}) begin
          code_d = '{KIND_EVENT, tag_q};
          cv_d   = 1'b1;
          tag_d  = 16'h0;
        end else if (|err_q && tag_q != 16'h0) begin
          for (int i = N - 1; i >= 0; i--) begin
            if (err_q[i]) code_d = '{KIND_ERROR, tag_q | 16'(i)};
          end
          cv_d  = 1'b1;
          err_d = err_q & (err_q - 1'b1);
        end else if (|pend_q) begin
          for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i]) code_d = '{KIND_ERROR, `ERR_DISABLED | 16'(i)};
          end
          cv_d   = 1'b1;
          pend_d = pend_q & (pend_q - 1'b1);
        end else if (~|en_q && ret_q != ST_HALT && ret_q != ST_POPCHK) begin
          // popcheck still runs first so that fill-order codes are not lost
          hcode_d = `HALT_NO_MEMORY;
          st_d    = ST_HALT;
        end else begin
          st_d  = ret_q;
          req_d = (ret_q == ST_TRAIN) || (ret_q == ST_THERMAL) || (ret_q == ST_CLEAR);
        end
      end
      ST_HALT: begin
        halt_d = 1'b1;
        zf_d   = 1'b0;
        code_d = '{KIND_HALT, {8'h00, hcode_q}};
        cv_d   = !halt_q;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      st_q <= ST_IDLE; ret_q <= ST_IDLE; en_q <= '0; pend_q <= '0; tag_q <= 16'h0;
      err_q <= '0; code_q <= '0; cv_q <= 1'b0; ecc_q <= 1'b0; zf_q <= 1'b0;
      req_q <= 1'b0; ras_q <= 2'h0; halt_q <= 1'b0; hcode_q <= 8'h00;
      wb_q <= 1'b0; poi_q <= 1'b0;
    end else begin
      st_q <= st_d; ret_q <= ret_d; en_q <= en_d; pend_q <= pend_d; tag_q <= tag_d;
      err_q <= err_d; code_q <= code_d; cv_q <= cv_d; ecc_q <= ecc_d; zf_q <= zf_d;
      req_q <= req_d; ras_q <= ras_d; halt_q <= halt_d; hcode_q <= hcode_d;
      wb_q <= wb_d; poi_q <= poi_d;
    end
  end

  assign o_step_req    = req_q;
  assign O_CODE        = code_q;
  assign O_CODE_VALID  = cv_q;
  assign O_DIMM_ENABLE = en_q;
  assign O_ECC_ENABLE  = ecc_q;
  assign O_ZERO_FILL   = zf_q;
  assign O_RAS_MODE    = ras_q;
  assign O_WRITE_BACK  = wb_q;
  assign O_POISON      = poi_q;
  assign O_HALTED      = halt_q;
endmodule : mem_init_seq

// file: rtl/mem_init_seq_defines.svh
// Purpose: constants for the memory bring-up sequencer
// Assumes: included by bare name
// Notes:   halt codes are 8-bit, error codes are 16-bit, per-slot ones with slot index in low nibble
`ifndef MEM_INIT_SEQ_DEFINES_SVH
`define MEM_INIT_SEQ_DEFINES_SVH
`define HALT_LOCKED        8'hE9
`define HALT_NO_MEMORY     8'hE8
`define HALT_POPULATION    8'hED
`define HALT_TRAINING      8'hEA
`define HALT_THERMAL       8'hEF
`define SHOW_SELF_TEST     8'hEB
`define ERR_RAS_FALLBACK   16'h8500
`define ERR_POPULATION     16'h8501
`define ERR_SELF_TEST      16'h8520
`define ERR_DISABLED       16'h8540
`define ERR_PRESENCE       16'h8560
`define SENSOR_RAS_TYPE    8'h0C
`define MAX_SPARE_RANKS    4'h4
`define MAX_RANKS          4'h8
`define RM_TWO             3'h2
`define RM_FOUR            3'h4
`endif

// file: rtl/mem_init_seq_pkg.sv
// Purpose: types for the memory bring-up sequencer
// Assumes: nothing
// Notes:   code kinds tell the logger how to treat each code
package mem_init_seq_pkg;
  typedef enum logic [1:0] {
    KIND_PROGRESS = 2'h0,
    KIND_HALT     = 2'h1,
    KIND_ERROR    = 2'h2,
    KIND_EVENT    = 2'h3
  } code_kind_t;
  typedef struct packed {
    code_kind_t  kind;
    logic [15:0] value;
  } code_t;
  // per-slot presence-detect summary captured from the DIMM
  typedef struct packed {
    logic       present;
    logic       read_err;
    logic       supported;
    logic       quad_rank;
    logic       load_reduced;
    logic       rank_mult;
    logic [2:0] rm_factor;
  } slot_info_t;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DISCVR  = 4'h1,
    ST_POPCHK  = 4'h3,
    ST_TRAIN   = 4'h2,
    ST_THERMAL = 4'h6,
    ST_SELFTST = 4'h7,
    ST_CLEAR   = 4'h5,
    ST_RAS     = 4'h4,
    ST_RUN     = 4'hC,
    ST_HALT    = 4'hD,
    ST_EMIT    = 4'hF
  } state_t;
endpackage : mem_init_seq_pkg

// file: testbench/mem_init_seq_asserts.sv
// Purpose: port checks for the memory bring-up sequencer
// Assumes: slot data and rank counts stay steady through a run
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
`include "mem_init_seq_defines.svh"
module mem_init_seq_asserts
  import mem_init_seq_pkg::*;
#(parameter int CHANNELS = 4, parameter int SLOTS = 3) (
  input wire logic                            I_CLK_SYS,
  input wire logic                            I_RST,
  input wire slot_info_t [CHANNELS*SLOTS-1:0] i_slot_info,
  input wire logic [3:0]                      i_spare_ranks,
  input wire logic                            i_rd_correctable,
  input wire code_t                           O_CODE,
  input wire logic                            O_CODE_VALID,
  input wire logic [CHANNELS*SLOTS-1:0]       O_DIMM_ENABLE,
  input wire logic                            O_ECC_ENABLE,
  input wire logic                            O_ZERO_FILL,
  input wire logic [1:0]                      O_RAS_MODE,
  input wire logic                            O_WRITE_BACK,
  input wire logic                            O_HALTED
);
  // ----------
  // helper logic
  // ----------
  logic gap;
  logic zeroed_q;
  logic zeroed_d;
  // enabled slots must run unbroken from slot 0, a hole means a missed cascade
  always_comb begin
    gap = 1'b0;
    for (int i = 1; i < CHANNELS*SLOTS; i++) begin
      if (i % SLOTS != 0) gap = gap | (O_DIMM_ENABLE[i] & ~O_DIMM_ENABLE[i-1]);
    end
  end
  // remembers that a zero fill happened since reset
  always_comb zeroed_d = zeroed_q | O_ZERO_FILL;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) zeroed_q <= 1'b0;
    else zeroed_q <= zeroed_d;
  end
  function automatic logic [CHANNELS*SLOTS-1:0] i_slot_info_present();
    for (int i = 0; i < CHANNELS*SLOTS; i++) i_slot_info_present[i] = i_slot_info[i].present;
  endfunction : i_slot_info_present
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  sequence halt_code_s;
    O_CODE_VALID && O_CODE.kind == KIND_HALT;
  endsequence
  sequence halt_kept_s;
    O_HALTED [*8];
  endsequence
  chk_halt_sticky: assert property (O_HALTED |=> O_HALTED)
    else $error("halted flag dropped");
  chk_halt_raised: assert property (halt_code_s |-> ##[0:4] halt_kept_s)
    else $error("halt code without held halt");
  chk_halt_value: assert property (halt_code_s |-> O_CODE.value[7:0] inside {`HALT_LOCKED,
    `HALT_NO_MEMORY, `HALT_POPULATION, `HALT_TRAINING, `HALT_THERMAL})
    else $error("unknown halt code");
  chk_event_code: assert property (O_CODE_VALID && O_CODE.kind == KIND_EVENT
    |-> O_CODE.value == {8'h00, `SENSOR_RAS_TYPE})
    else $error("bad event sensor type");
  chk_enable_present: assert property ((O_DIMM_ENABLE & ~i_slot_info_present()) == '0)
    else $error("absent slot enabled");
  chk_enable_run: assert property (!gap)
    else $error("slot enabled behind a disabled one");
  chk_ecc_zeroed: assert property ($rose(O_ECC_ENABLE) |-> zeroed_q)
    else $error("ecc enabled before zero fill");
  chk_write_back: assert property (O_WRITE_BACK |-> $past(i_rd_correctable))
    else $error("write back without correctable read");
  chk_spare_limit: assert property (O_RAS_MODE == 2'h2 |-> i_spare_ranks <= `MAX_SPARE_RANKS)
    else $error("too many spare ranks");
endmodule : mem_init_seq_asserts
bind mem_init_seq mem_init_seq_asserts #(.CHANNELS(CHANNELS), .SLOTS(SLOTS)) chk_u (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_slot_info(i_slot_info),
  .i_spare_ranks(i_spare_ranks), .i_rd_correctable(i_rd_correctable), .O_CODE(O_CODE),
  .O_CODE_VALID(O_CODE_VALID), .O_DIMM_ENABLE(O_DIMM_ENABLE), .O_ECC_ENABLE(O_ECC_ENABLE),
  .O_ZERO_FILL(O_ZERO_FILL), .O_RAS_MODE(O_RAS_MODE), .O_WRITE_BACK(O_WRITE_BACK),
  .O_HALTED(O_HALTED));

// file: testbench/mem_init_seq_dimms.sv
// Purpose: stand-in for the DIMMs and channel engines answering steps
// Assumes: one step request outstanding at a time
// Notes:   slow mode makes every step wait eight cycles
`timescale 1ns/1ps
module mem_init_seq_dimms (
  input  wire logic I_CLK_SYS,
  input  wire logic I_RST,
  input  wire logic i_step_req,
  input  wire logic i_slow,
  output logic      o_step_done
);
  logic [3:0] wait_q;
  logic       busy_q;
  // done pulses once when the pending step's countdown runs out
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      {busy_q, wait_q, o_step_done} <= 6'h00;
    end else begin
      o_step_done <= busy_q && wait_q == 4'h0;
      busy_q      <= i_step_req || (busy_q && wait_q != 4'h0);
      if (i_step_req) wait_q <= i_slow ? 4'h7 : 4'h0;
      else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    end
  end
endmodule : mem_init_seq_dimms

// file: testbench/memory_init_error_sequencer_test.sv
// Purpose: self-checking bench for the memory bring-up sequencer
// Assumes: one bring-up per reset, inputs steady while it runs
// Notes:   slot kinds one nibble a slot, index channel*3+slot
`timescale 1ns/1ps
`include "mem_init_seq_defines.svh"
module memory_init_error_sequencer_test import mem_init_seq_pkg::*;;
  typedef struct packed {
    logic [47:0] slots;
    logic        lock;
    logic [3:0]  train;
    logic        therm;
    logic [11:0] bist;
    logic [3:0]  spare;
    logic [7:0]  halt;
    logic [11:0] en;
    logic [15:0] code;
  } row_t;
  // ----------
  // ordinary cases, spare nonzero selects sparing
  // ----------
  row_t rows [15] = '{
    '{48'h1001001001, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'h0, 12'h249, 16'h0},
    '{48'h1001001001, 1'h1, 4'hF, 1'h0, 12'h0, 4'h0, 8'hE9, 12'h0, 16'h0},
    '{48'h0, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'hE8, 12'h0, 16'h0},
    '{48'h1012, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'h0, 12'h008, 16'h8541},
    '{48'h3, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'hED, 12'h0, 16'h8501},
    '{48'h1010, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'h0, 12'h008, 16'h8541},
    '{48'h411, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'hED, 12'h0, 16'h8501},
    '{48'h555, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'h0, 12'h007, 16'h0},
    '{48'h6001, 1'h0, 4'hF, 1'h0, 12'h0, 4'h0, 8'hED, 12'h0, 16'h8501},
    '{48'h1001, 1'h0, 4'h1, 1'h0, 12'h0, 4'h0, 8'h0, 12'h001, 16'h8543},
    '{48'h1001, 1'h0, 4'h0, 1'h0, 12'h0, 4'h0, 8'hEA, 12'h0, 16'h0},
    '{48'h1, 1'h0, 4'hF, 1'h1, 12'h0, 4'h0, 8'hEF, 12'h0, 16'h0},
    '{48'h1011, 1'h0, 4'hF, 1'h0, 12'h1, 4'h0, 8'h0, 12'h008, 16'h8520},
    '{48'h1001, 1'h0, 4'hF, 1'h0, 12'h0, 4'h4, 8'h0, 12'h009, 16'h0},
    '{48'h1001, 1'h0, 4'hF, 1'h0, 12'h0, 4'h5, 8'h0, 12'h009, 16'h8500}};
  logic        I_CLK_SYS = 1'b0;
  logic        I_RST, i_start, i_mem_locked, i_step_done, i_thermal_cfg_err, slow, got;
  logic        i_rd_correctable, i_patrol_uncorrected, o_step_req, O_CODE_VALID;
  logic        O_ECC_ENABLE, O_ZERO_FILL, O_WRITE_BACK, O_POISON, O_HALTED;
  logic [3:0]  i_train_ok, i_spare_ranks;
  logic [11:0] i_selftest_fail, O_DIMM_ENABLE;
  logic [1:0]  O_RAS_MODE;
  logic [47:0] slots;
  logic [7:0]  halt_seen;
  logic [15:0] want;
  slot_info_t [11:0] i_slot_info;
  code_t       O_CODE;
  int          bad_count = 0;
  int          comparisons = 0;
  always #5 I_CLK_SYS = ~I_CLK_SYS;
  // slot kind nibble to presence-detect summary
  always_comb begin
    for (int s = 0; s < 12; s++) begin
      case (slots[s*4 +: 4])
        4'h1: i_slot_info[s] = slot_info_t'(9'h140);
        4'h2: i_slot_info[s] = slot_info_t'(9'h1C0);
        4'h3: i_slot_info[s] = slot_info_t'(9'h100);
        4'h4: i_slot_info[s] = slot_info_t'(9'h160);
        4'h5: i_slot_info[s] = slot_info_t'(9'h17A);
        4'h6: i_slot_info[s] = slot_info_t'(9'h150);
        default: i_slot_info[s] = slot_info_t'(9'h000);
      endcase
    end
  end
  mem_init_seq #(.CHANNELS(4), .SLOTS(3)) dut_u (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_start(i_start), .i_mem_locked(i_mem_locked),
    .i_slot_info(i_slot_info), .i_step_done(i_step_done), .i_train_ok(i_train_ok),
    .i_thermal_cfg_err(i_thermal_cfg_err), .i_selftest_fail(i_selftest_fail),
    .i_ras_select(i_spare_ranks != 4'h0 ? 2'h2 : 2'h0), .i_spare_ranks(i_spare_ranks),
    .i_total_ranks(4'h8), .i_rd_correctable(i_rd_correctable),
    .i_patrol_uncorrected(i_patrol_uncorrected), .o_step_req(o_step_req), .O_CODE(O_CODE),
    .O_CODE_VALID(O_CODE_VALID), .O_DIMM_ENABLE(O_DIMM_ENABLE), .O_ECC_ENABLE(O_ECC_ENABLE),
    .O_ZERO_FILL(O_ZERO_FILL), .O_RAS_MODE(O_RAS_MODE), .O_WRITE_BACK(O_WRITE_BACK),
    .O_POISON(O_POISON), .O_HALTED(O_HALTED));
  mem_init_seq_dimms dimm_u (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_step_req(o_step_req),
    .i_slow(slow), .o_step_done(i_step_done));
  // halt codes and the wanted code are caught as they stream past
  // both catchers are cleared by reset, so each row starts from nothing
  always @(posedge I_CLK_SYS) begin
    if (I_RST === 1'b1) begin
      got       <= 1'b0;
      halt_seen <= 8'h00;
    end else begin
      if (O_CODE_VALID === 1'b1 && O_CODE.kind === KIND_HALT) halt_seen <= O_CODE.value[7:0];
      if (O_CODE_VALID === 1'b1 && O_CODE.value === want) got <= 1'b1;
    end
  end
  task automatic tick();
    @(posedge I_CLK_SYS);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // reset lands once the previous row has settled, then one full bring-up
  task automatic run_row(input row_t r, input logic s);
    int n;
    I_RST = 1'b1;
    slow = s;
    want = r.code;
    slots = r.slots;
    i_mem_locked = r.lock;
    i_train_ok = r.train;
    i_thermal_cfg_err = r.therm;
    i_selftest_fail = r.bist;
    i_spare_ranks = r.spare;
    repeat (20) tick();
    I_RST = 1'b0;
    i_start = 1'b1;
    tick();
    i_start = 1'b0;
    n = 0;
    while (O_HALTED !== 1'b1 && O_ECC_ENABLE !== 1'b1 && n < 500) begin
      tick();
      n++;
    end
    if (n >= 500) bad_count++;
    if (n >= 500) report_and_stop();
    repeat (30) tick();
  endtask : run_row
  initial begin
    {i_start, i_rd_correctable, i_patrol_uncorrected} = 3'h0;
    for (int i = 0; i < 15; i++) begin
      run_row(rows[i], i[0]);
      check("halt code", {8'h0, halt_seen}, {8'h0, rows[i].halt});
      check("halted", {15'h0, O_HALTED}, {15'h0, rows[i].halt != 8'h0});
      if (rows[i].halt != 8'hED && rows[i].halt != 8'hEF)
        check("dimm enable", {4'h0, O_DIMM_ENABLE}, {4'h0, rows[i].en});
      if (rows[i].code != 16'h0) check("code", {15'h0, got}, 16'h1);
      check("ecc", {15'h0, O_ECC_ENABLE}, {15'h0, rows[i].halt == 8'h0});
      check("ras", {14'h0, O_RAS_MODE}, (rows[i].spare == 4'h4) ? 16'h2 : 16'h0);
    end
    // demand scrub and patrol poison follow their cause by one cycle
    run_row(rows[0], 1'b0);
    i_rd_correctable = 1'b1;
    tick();
    check("write back", {15'h0, O_WRITE_BACK}, 16'h1);
    {i_rd_correctable, i_patrol_uncorrected} = 2'h1;
    tick();
    check("poison", {14'h0, O_WRITE_BACK, O_POISON}, 16'h1);
    i_patrol_uncorrected = 1'b0;
    tick();
    check("quiet", {14'h0, O_WRITE_BACK, O_POISON}, 16'h0);
    // a halt holds only until reset
    run_row(rows[1], 1'b1);
    I_RST = 1'b1;
    tick();
    check("reset", {13'h0, O_HALTED, O_ECC_ENABLE, O_CODE_VALID}, 16'h0);
    report_and_stop();
  end
endmodule : memory_init_error_sequencer_test
